// [clk_switch_pkg.sv]
// constants and types for the reference clock switchover block
package clk_switch_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_PERIOD0 = 8'h08;
  localparam logic [7:0] ADDR_PERIOD1 = 8'h0C;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 1;
  localparam int CTRL_PDHOLD   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status register fields
  localparam int STAT_LOSS0  = 0;
  localparam int STAT_LOSS1  = 1;
  localparam int STAT_ACTIVE = 2;
  localparam int STAT_GATED  = 3;
  localparam int STAT_REQ    = 4;
  localparam int STAT_ST_LSB = 5;
  localparam int STAT_ST_MSB = 6;

  // a clock is lost after this many of its own periods without a rise
  localparam int LOSS_PERIODS = 2;

  // reset values
  localparam logic SEL_RESET  = 1'b0;
  localparam logic GATE_RESET = 1'b1;

  typedef enum logic [1:0]
  {
    MODE_AUTO     = 2'b00,
    MODE_MANUAL   = 2'b01,
    MODE_OVERRIDE = 2'b10
  } sw_mode_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_GATE = 2'b01,
    ST_SWAP = 2'b10
  } sw_state_t;

endpackage : clk_switch_pkg

// [clk_switchover.sv]
// reference clock switchover controller with apb register access
`timescale 1ns/1ps

module clk_switchover
  import clk_switch_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              primary_ref_clock,
  input  wire logic              backup_ref_clock,
  input  wire logic              switch_request,
  output logic                   ref_clock_out,
  output logic                   ref_select,
  output logic                   ref_gate_en,
  output logic      [1:0]        ref_loss,
  output logic                   phase_detector_enable
);

  // synchronisers and edge history for both reference inputs
  logic [1:0]       ref_meta_r;
  logic [1:0]       ref_sync_r;
  logic [1:0]       ref_prev_r;
  logic [1:0]       ref_rise;
  logic [1:0]       ref_fall;

  // request synchroniser
  logic             req_meta_r;
  logic             req_sync_r;
  logic             req_prev_r;
  logic             req_rise;

  // loss sensing
  logic [CNT_W-1:0] idle_cnt_r [2];
  logic [CNT_W-1:0] period_r   [2];
  logic             seen_r     [2];
  logic [1:0]       lost;
  logic [1:0]       loss_r;

  // switch state
  sw_state_t        state_r;
  logic             sel_r;
  logic             gate_r;
  logic             pd_en_r;

  // registers
  logic [2:0]       ctrl_r;
  sw_mode_t         mode;
  logic             auto_ok;
  logic             manual_ok;
  logic             cur_lost;
  logic             alt_lost;

  // apb
  logic             setup;
  logic             access;
  logic [7:0]       addr8;
  logic [31:0]      rd_mux;
  logic             rd_err;
  logic [31:0]      prdata_r;
  logic             pslverr_r;

  // inputs from pins pass two flops before any logic but the output mux reads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_meta_r <= 2'h0;
      ref_sync_r <= 2'h0;
      ref_prev_r <= 2'h0;
    end
    else if (clk_en)
    begin
      ref_meta_r <= {backup_ref_clock, primary_ref_clock};
      ref_sync_r <= ref_meta_r;
      ref_prev_r <= ref_sync_r;
    end
  end

  assign ref_rise = ref_sync_r & ~ref_prev_r;
  assign ref_fall = ~ref_sync_r & ref_prev_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
      req_prev_r <= 1'b0;
    end
    else if (clk_en)
    begin
      req_meta_r <= switch_request;
      req_sync_r <= req_meta_r;
      req_prev_r <= req_sync_r;
    end
  end

  // only the rising edge of the request starts a switch
  assign req_rise = req_sync_r & ~req_prev_r;

  // per input: measure its period, flag it lost after two idle periods
  for (genvar i = 0; i < 2; i++)
  begin : g_sense
    logic [CNT_W:0] limit;

    // an input never seen rising waits for counter saturation
    assign limit = (period_r[i] == '0) ? {1'b0, {CNT_W{1'b1}}}
                 : (CNT_W+1)'(LOSS_PERIODS) * {1'b0, period_r[i]};
    assign lost[i] = ({1'b0, idle_cnt_r[i]} >= limit);

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        idle_cnt_r[i] <= '0;
        period_r[i]   <= '0;
        seen_r[i]     <= 1'b0;
      end
      else if (clk_en)
      begin
        if (ref_rise[i])
        begin
          idle_cnt_r[i] <= '0;
          seen_r[i]     <= 1'b1;
          // the gap from reset or from a restart is no period: skip it,
          // else a short first gap flags a running input as lost
          if (seen_r[i] && !loss_r[i])
          begin
            if (idle_cnt_r[i] != '1)
              period_r[i] <= idle_cnt_r[i] + 1'b1;
            else
              period_r[i] <= idle_cnt_r[i];
          end
        end
        else if (idle_cnt_r[i] != '1)
        begin
          idle_cnt_r[i] <= idle_cnt_r[i] + 1'b1;
        end
      end
    end

    // sticky until the input rises again
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        loss_r[i] <= 1'b0;
      else if (clk_en)
      begin
        if (ref_rise[i])
          loss_r[i] <= 1'b0;
        else if (lost[i])
          loss_r[i] <= 1'b1;
      end
    end
  end

  // mode decode; the unused code behaves as automatic
  always_comb
  begin
    unique case (ctrl_r[CTRL_MODE_MSB:CTRL_MODE_LSB])
      2'b00:   mode = MODE_AUTO;
      2'b01:   mode = MODE_MANUAL;
      2'b10:   mode = MODE_OVERRIDE;
      default: mode = MODE_AUTO;
    endcase
  end

  // a held request in override mode blocks automatic action
  assign auto_ok   = (mode == MODE_AUTO)
                   || ((mode == MODE_OVERRIDE) && !req_sync_r);
  assign manual_ok = (mode == MODE_MANUAL) || (mode == MODE_OVERRIDE);
  assign cur_lost  = loss_r[sel_r];
  assign alt_lost  = loss_r[~sel_r];

  // switchover sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      sel_r   <= SEL_RESET;
      gate_r  <= GATE_RESET;
    end
    else if (clk_en)
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (manual_ok && req_rise)
          begin
            state_r <= ST_GATE;
          end
          else if (auto_ok && cur_lost && !alt_lost)
          begin
            // the dead input gives no falling edge: gate at once
            gate_r  <= 1'b0;
            state_r <= ST_SWAP;
          end
        end
        ST_GATE:
        begin
          if (ref_fall[sel_r])
          begin
            gate_r  <= 1'b0;
            state_r <= ST_SWAP;
          end
        end
        ST_SWAP:
        begin
          // stays here until the target input falls
          if (ref_fall[~sel_r])
          begin
            sel_r   <= ~sel_r;
            gate_r  <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // optional hold of the phase detector while an input is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pd_en_r <= 1'b1;
    else if (clk_en)
      pd_en_r <= !(ctrl_r[CTRL_PDHOLD] && (loss_r != 2'b00));
  end

  // glitch-free: the gate closes after the selected input falls, or at once on a loss, and reopens with the new select after the target input falls
  assign ref_clock_out = gate_r
                       && (sel_r ? backup_ref_clock : primary_ref_clock);
  assign ref_select            = sel_r;
  assign ref_gate_en           = gate_r;
  assign ref_loss              = loss_r;
  assign phase_detector_enable = pd_en_r;

  // apb slave: read data latched in setup, answered in first access cycle
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign addr8  = 8'(paddr);

  always_comb
  begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    if (paddr[ADDR_W-1:2] != addr8[7:2] || addr8 > ADDR_PERIOD1
        || addr8[1:0] != 2'b00)
    begin
      rd_err = 1'b1;
    end
    else
    begin
      unique case (addr8)
        ADDR_CTRL:
          rd_mux[2:0] = ctrl_r;
        ADDR_STATUS:
        begin
          rd_mux[STAT_LOSS0]  = loss_r[0];
          rd_mux[STAT_LOSS1]  = loss_r[1];
          rd_mux[STAT_ACTIVE] = sel_r;
          rd_mux[STAT_GATED]  = !gate_r;
          rd_mux[STAT_REQ]    = req_sync_r;
          rd_mux[STAT_ST_MSB:STAT_ST_LSB] = state_r;
        end
        ADDR_PERIOD0:
          rd_mux[CNT_W-1:0] = period_r[0];
        ADDR_PERIOD1:
          rd_mux[CNT_W-1:0] = period_r[1];
        default:
          rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else if (clk_en && setup)
    begin
      prdata_r  <= pwrite ? 32'h0 : rd_mux;
      pslverr_r <= rd_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= CTRL_RESET;
    else if (clk_en && access && pwrite && pstrb[0] && !pslverr_r
             && addr8 == ADDR_CTRL)
      ctrl_r <= pwdata[2:0];
  end

  assign pready  = clk_en;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r && access;

endmodule : clk_switchover

// [clk_switch_assertions.sv]
// assertion checker for the reference clock switchover block
`timescale 1ns/1ps
module clk_switch_assertions
#(
  parameter int ADDR_W = 8
)
(
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic [ADDR_W-1:0] paddr,
  input logic              pslverr,
  input logic              primary_ref_clock,
  input logic              backup_ref_clock,
  input logic              ref_clock_out,
  input logic              ref_select,
  input logic              ref_gate_en,
  input logic [1:0]        ref_loss,
  input logic              phase_detector_enable
);
  localparam int LOSS_MAX = 60;
  logic [7:0] idle0_r;
  // cycles the primary pin has sat low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle0_r <= 8'h00;
    else if (primary_ref_clock)
      idle0_r <= 8'h00;
    else if (idle0_r != 8'hFF)
      idle0_r <= idle0_r + 8'h01;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_sel_gated;
    $changed(ref_select) |-> ref_gate_en && !$past(ref_gate_en);
  endproperty
  a_sel_gated: assert property (p_sel_gated)
    else $error("select changed outside a gated switch");
  property p_out_gated;
    !ref_gate_en |-> !ref_clock_out;
  endproperty
  a_out_gated: assert property (p_out_gated)
    else $error("output not gated");
  property p_out_mux;
    ref_gate_en |->
      ref_clock_out == (ref_select ? backup_ref_clock : primary_ref_clock);
  endproperty
  a_out_mux: assert property (p_out_mux)
    else $error("output does not follow selected input");
  property p_gate_bound;
    $fell(ref_gate_en) |-> ##[1:120] ref_gate_en;
  endproperty
  a_gate_bound: assert property (p_gate_bound)
    else $error("switch did not complete");
  property p_loss_clr0;
    $rose(primary_ref_clock) |-> ##[1:6] !ref_loss[0];
  endproperty
  a_loss_clr0: assert property (p_loss_clr0)
    else $error("primary loss flag stuck");
  property p_loss_clr1;
    $rose(backup_ref_clock) |-> ##[1:6] !ref_loss[1];
  endproperty
  a_loss_clr1: assert property (p_loss_clr1)
    else $error("backup loss flag stuck");
  property p_loss_set0;
    idle0_r == LOSS_MAX |-> ref_loss[0];
  endproperty
  a_loss_set0: assert property (p_loss_set0)
    else $error("primary loss not flagged");
  property p_pde;
    !phase_detector_enable |-> $past(|ref_loss);
  endproperty
  a_pde: assert property (p_pde)
    else $error("phase detector off without loss");
  property p_err;
    psel && penable && |paddr[ADDR_W-1:4] |-> pslverr;
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped access without error");
  c_sw: cover property ($changed(ref_select));
  c_loss: cover property ($rose(ref_loss[0]));
  c_err: cover property (psel && penable && pslverr);
endmodule : clk_switch_assertions
bind clk_switchover clk_switch_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .primary_ref_clock, .backup_ref_clock, .ref_clock_out,
  .ref_select, .ref_gate_en, .ref_loss, .phase_detector_enable
);

// [ref_src.sv]
// two reference clock sources that stop low when told to
`timescale 1ns/1ps
module ref_src
(
  input  logic [1:0] run,
  input  logic       sel,
  output logic       primary_ref_clock,
  output logic       backup_ref_clock,
  output logic       loop_rst
);
  initial
  begin
    primary_ref_clock = 1'b0;
    backup_ref_clock = 1'b0;
    loop_rst = 1'b0;
  end
  // loop and clock network held off 10 ns after each switchover
  always @(sel)
  begin
    loop_rst = 1'b1;
    #10 loop_rst = 1'b0;
  end
  // periods 160 ns and 180 ns stay well inside a factor of two
  always #80 primary_ref_clock = run[0] ? !primary_ref_clock : 1'b0;
  always #90 backup_ref_clock = run[1] ? !backup_ref_clock : 1'b0;
endmodule : ref_src

// [testbench.sv]
// self-checking testbench for the reference clock switchover block
`timescale 1ns/1ps
module testbench;
  import clk_switch_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        primary_ref_clock, backup_ref_clock, switch_request, e;
  logic        ref_select, ref_gate_en, phase_detector_enable;
  logic        ref_clock_out, loop_rst;
  logic [1:0]  ref_loss, run;
  int          n_mismatch, checks, exp_sel, h, n_exp, n_sw;
  clk_switchover u_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .primary_ref_clock, .backup_ref_clock, .switch_request,
    .ref_clock_out, .ref_select, .ref_gate_en, .ref_loss,
    .phase_detector_enable);
  ref_src u_src (.run, .sel(ref_select), .primary_ref_clock,
    .backup_ref_clock, .loop_rst);
  // count the loop resets that real switchovers cause
  always @(posedge loop_rst)
    if (presetn === 1'b1)
      n_sw++;
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", n, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_sel;
    n_exp++;
    for (int i = 0; i < 400 && ref_select !== exp_sel[0]; i++)
      @(negedge pclk);
    chk("select", exp_sel, 32'(ref_select));
    chk("gate", 1, 32'(ref_gate_en));
    @(posedge pclk);
    q = exp_sel[0] ? backup_ref_clock : primary_ref_clock;
    chk("clkout", q, 32'(ref_clock_out));
  endtask : wait_sel
  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, switch_request} = 5'h00;
    {paddr, pwdata, n_mismatch, checks, exp_sel} = '0;
    run = 2'b11;
    h = $urandom(32'hB48A);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (60) @(posedge pclk);
    chk("select", 0, 32'(ref_select));
    chk("loss", 0, 32'(ref_loss));
    apb(1'b1, ADDR_CTRL, 32'h4);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h4, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 1, 32'(e));
    $display("test registers done");
    run[0] <= 1'b0;
    exp_sel = 1;
    wait_sel;
    chk("loss", 1, 32'(ref_loss));
    chk("pde", 0, 32'(phase_detector_enable));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h5, q);
    run[0] <= 1'b1;
    repeat (60) @(posedge pclk);
    chk("loss", 0, 32'(ref_loss));
    run[1] <= 1'b0;
    exp_sel = 0;
    wait_sel;
    chk("loss", 2, 32'(ref_loss));
    run[1] <= 1'b1;
    repeat (60) @(posedge pclk);
    $display("test automatic done");
    apb(1'b1, ADDR_CTRL, 32'(MODE_MANUAL));
    repeat (4)
    begin
      switch_request <= 1'b1;
      h = 60 + $urandom % 40;
      repeat (h) @(posedge pclk);
      exp_sel = 1 - exp_sel;
      wait_sel;
      chk("loss", 0, 32'(ref_loss));
      switch_request <= 1'b0;
      repeat (40) @(posedge pclk);
      chk("select", exp_sel, 32'(ref_select));
    end
    $display("test manual done");
    apb(1'b1, ADDR_CTRL, 32'(MODE_OVERRIDE));
    switch_request <= 1'b1;
    repeat (80) @(posedge pclk);
    exp_sel = 1 - exp_sel;
    wait_sel;
    run[exp_sel] <= 1'b0;
    repeat (150) @(posedge pclk);
    chk("select", exp_sel, 32'(ref_select));
    run <= 2'b11;
    repeat (60) @(posedge pclk);
    chk("switches", n_exp, n_sw);
    switch_request <= 1'b0;
    $display("test override done");
    end_sim;
  end
endmodule : testbench
